/* core/irq_priority_ext_edge_detect.sv */
// Interrupt priority selection and external line edge detection with an APB register slave.
`default_nettype none

// Operation
// - Source level is {high bit, low bit}: 00 lowest up to 11 highest.
// - Four priority pairs; bit x of pair n ranks source enabled by bit x of group n.
// - Selected edge on lines 0 to 7 sets its bit in the first flag register.
// - Selected edge on lines 10 to 17 sets bits 0 to 7 of the second flag register.
// - Lines 8, 9, A, 18, 19 flag in bits 0 to 4 of the third register.
// - Writing zero clears a pending flag; writing one leaves it unchanged.
// - Edge select codes: 00 none, 01 rising, 10 falling, 11 both.
// - First select pair: lines 0 to 3 low, 4 to 7 high, two bits each.
// - Second select pair: lines 10 to 13 low, 14 to 17 high.
// - Third select pair: lines 8, 9, A low bits 5:0, lines 18, 19 high bits 3:0.
// - Only a strictly higher level preempts the routine in service.
// - Equal levels: the lower-numbered source is served first.
// - A request needs the global enable bit and its own enable bit.
module irq_priority_ext_edge_detect (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire irq_prio_pkg::apb_req_type apb_in,
    output irq_prio_pkg::apb_resp_type apb_out,
    input wire logic [23:0] periph_irq,
    input wire logic [20:0] external_irq_line,
    input wire logic irq_ack,
    input wire logic svc_done,
    output irq_prio_pkg::irq_vec_type irq_out
);

    // ****************************************************************
    // Registers.
    // ****************************************************************
    logic [3:0][7:0] prio_low;
    logic [3:0][7:0] prio_high;
    logic [3:0][7:0] irq_enable;
    logic [20:0] line_pending_bit;
    logic [7:0] edge_sel_lines_0_3;
    logic [7:0] edge_sel_lines_4_7;
    logic [7:0] edge_sel_lines_10_13;
    logic [7:0] edge_sel_lines_14_17;
    logic [7:0] edge_sel_lines_8_9_a;
    logic [7:0] edge_sel_lines_18_19;
    logic [20:0] sync_a;
    logic [20:0] sync_b;
    logic [20:0] sync_c;
    logic [3:0] in_service;

    // ****************************************************************
    // Bus decode.
    // ****************************************************************
    logic [7:0] word_idx;
    logic addr_ok;
    logic hit;
    logic [7:0] rd_value;
    logic [7:0] wd;
    logic wr_en;
    logic access;

    assign word_idx = apb_in.paddr[9:2];
    assign addr_ok = (apb_in.paddr[1:0] == 2'h0) && (apb_in.paddr[11:10] == 2'h0);
    assign wd = apb_in.pwdata[7:0];
    assign access = apb_in.psel && apb_in.penable && !apb_out.pready;
    assign wr_en = apb_in.psel && apb_in.penable && apb_out.pready && apb_in.pwrite && hit;

    always_comb begin
        rd_value = 8'h00;
        hit = addr_ok;
        case (word_idx)
            irq_prio_pkg::IDX_PRIO_G0_LOW: rd_value = prio_low[0];
            irq_prio_pkg::IDX_PRIO_G0_HIGH: rd_value = prio_high[0];
            irq_prio_pkg::IDX_PRIO_G1_LOW: rd_value = prio_low[1];
            irq_prio_pkg::IDX_PRIO_G1_HIGH: rd_value = prio_high[1];
            irq_prio_pkg::IDX_PRIO_G2_LOW: rd_value = prio_low[2];
            irq_prio_pkg::IDX_PRIO_G2_HIGH: rd_value = prio_high[2];
            irq_prio_pkg::IDX_PRIO_G3_LOW: rd_value = prio_low[3];
            irq_prio_pkg::IDX_PRIO_G3_HIGH: rd_value = prio_high[3];
            irq_prio_pkg::IDX_EXT_PEND_0_7: rd_value = line_pending_bit[7:0];
            irq_prio_pkg::IDX_EXT_PEND_10_17: rd_value = line_pending_bit[15:8];
            irq_prio_pkg::IDX_EXT_PEND_MISC: rd_value = {3'h0, line_pending_bit[20:16]};
            irq_prio_pkg::IDX_EDGE_SEL_0_3: rd_value = edge_sel_lines_0_3;
            irq_prio_pkg::IDX_EDGE_SEL_4_7: rd_value = edge_sel_lines_4_7;
            irq_prio_pkg::IDX_EDGE_SEL_10_13: rd_value = edge_sel_lines_10_13;
            irq_prio_pkg::IDX_EDGE_SEL_14_17: rd_value = edge_sel_lines_14_17;
            irq_prio_pkg::IDX_EDGE_SEL_8_9_A: rd_value = edge_sel_lines_8_9_a;
            irq_prio_pkg::IDX_EDGE_SEL_18_19: rd_value = edge_sel_lines_18_19;
            irq_prio_pkg::IDX_IRQ_EN_GROUP0: rd_value = irq_enable[0];
            irq_prio_pkg::IDX_IRQ_EN_GROUP1: rd_value = irq_enable[1];
            irq_prio_pkg::IDX_IRQ_EN_GROUP2: rd_value = irq_enable[2];
            irq_prio_pkg::IDX_IRQ_EN_GROUP3: rd_value = irq_enable[3];
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // One wait state: the answer is registered in the first access cycle.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            apb_out <= '0;
        end else begin
            apb_out.pready <= access;
            apb_out.pslverr <= access && !hit;
            apb_out.prdata <= (access && hit) ? {24'h0, rd_value} : 32'h0;
        end
    end

    // ****************************************************************
    // Priority and enable registers.
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            prio_low <= {4{irq_prio_pkg::REG_RESET}};
            prio_high <= {4{irq_prio_pkg::REG_RESET}};
        end else if (wr_en) begin
            case (word_idx)
                irq_prio_pkg::IDX_PRIO_G0_LOW: prio_low[0] <= wd & irq_prio_pkg::MASK_PRIO;
                irq_prio_pkg::IDX_PRIO_G0_HIGH: prio_high[0] <= wd & irq_prio_pkg::MASK_PRIO;
                irq_prio_pkg::IDX_PRIO_G1_LOW: prio_low[1] <= wd & irq_prio_pkg::MASK_PRIO;
                irq_prio_pkg::IDX_PRIO_G1_HIGH: prio_high[1] <= wd & irq_prio_pkg::MASK_PRIO;
                irq_prio_pkg::IDX_PRIO_G2_LOW: prio_low[2] <= wd & irq_prio_pkg::MASK_PRIO;
                irq_prio_pkg::IDX_PRIO_G2_HIGH: prio_high[2] <= wd & irq_prio_pkg::MASK_PRIO;
                irq_prio_pkg::IDX_PRIO_G3_LOW: prio_low[3] <= wd & irq_prio_pkg::MASK_PRIO;
                irq_prio_pkg::IDX_PRIO_G3_HIGH: prio_high[3] <= wd & irq_prio_pkg::MASK_PRIO;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            irq_enable <= {4{irq_prio_pkg::REG_RESET}};
        end else if (wr_en) begin
            case (word_idx)
                irq_prio_pkg::IDX_IRQ_EN_GROUP0: begin
                    irq_enable[0] <= wd & irq_prio_pkg::MASK_EN_GROUP0;
                end
                irq_prio_pkg::IDX_IRQ_EN_GROUP1: begin
                    irq_enable[1] <= wd & irq_prio_pkg::MASK_EN_GROUP;
                end
                irq_prio_pkg::IDX_IRQ_EN_GROUP2: begin
                    irq_enable[2] <= wd & irq_prio_pkg::MASK_EN_GROUP;
                end
                irq_prio_pkg::IDX_IRQ_EN_GROUP3: begin
                    irq_enable[3] <= wd & irq_prio_pkg::MASK_EN_GROUP;
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************************************
    // Edge select registers.
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            edge_sel_lines_0_3 <= irq_prio_pkg::REG_RESET;
            edge_sel_lines_4_7 <= irq_prio_pkg::REG_RESET;
            edge_sel_lines_10_13 <= irq_prio_pkg::REG_RESET;
            edge_sel_lines_14_17 <= irq_prio_pkg::REG_RESET;
            edge_sel_lines_8_9_a <= irq_prio_pkg::REG_RESET;
            edge_sel_lines_18_19 <= irq_prio_pkg::REG_RESET;
        end else if (wr_en) begin
            case (word_idx)
                irq_prio_pkg::IDX_EDGE_SEL_0_3: begin
                    edge_sel_lines_0_3 <= wd;
                end
                irq_prio_pkg::IDX_EDGE_SEL_4_7: begin
                    edge_sel_lines_4_7 <= wd;
                end
                irq_prio_pkg::IDX_EDGE_SEL_10_13: begin
                    edge_sel_lines_10_13 <= wd;
                end
                irq_prio_pkg::IDX_EDGE_SEL_14_17: begin
                    edge_sel_lines_14_17 <= wd;
                end
                irq_prio_pkg::IDX_EDGE_SEL_8_9_A: begin
                    edge_sel_lines_8_9_a <= wd & irq_prio_pkg::MASK_SEL_8_9_A;
                end
                irq_prio_pkg::IDX_EDGE_SEL_18_19: begin
                    edge_sel_lines_18_19 <= wd & irq_prio_pkg::MASK_SEL_18_19;
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************************************
    // Pin synchronisers and edge detection.
    // ****************************************************************
    logic [41:0] line_edge_select;
    logic [20:0] rise;
    logic [20:0] fall;
    logic [20:0] line_event;
    irq_prio_pkg::edge_mode_type mode;

    // Lines 0-7, 10-17, then 8, 9, A, 18, 19 in pending-flag order.
    assign line_edge_select = {edge_sel_lines_18_19[3:0], edge_sel_lines_8_9_a[5:0], edge_sel_lines_14_17,
                               edge_sel_lines_10_13, edge_sel_lines_4_7, edge_sel_lines_0_3};

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            sync_a <= '0;
            sync_b <= '0;
            sync_c <= '0;
        end else begin
            sync_a <= external_irq_line;
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    assign rise = sync_b & ~sync_c;
    assign fall = ~sync_b & sync_c;

    always_comb begin
        mode = irq_prio_pkg::EDGE_NONE;
        line_event = '0;
        for (int k = 0; k < irq_prio_pkg::NUM_LINES; k++) begin
            mode = irq_prio_pkg::edge_mode_type'(line_edge_select[2*k +: 2]);
            case (mode)
                irq_prio_pkg::EDGE_RISE: begin
                    line_event[k] = rise[k];
                end
                irq_prio_pkg::EDGE_FALL: begin
                    line_event[k] = fall[k];
                end
                irq_prio_pkg::EDGE_BOTH: begin
                    line_event[k] = rise[k] | fall[k];
                end
                default: begin
                    line_event[k] = 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // Pending flags.
    // ****************************************************************
    logic [20:0] flag_clear;
    logic [20:0] next_pending;

    always_comb begin
        flag_clear = '0;
        if (wr_en) begin
            case (word_idx)
                irq_prio_pkg::IDX_EXT_PEND_0_7: begin
                    flag_clear[7:0] = ~wd;
                end
                irq_prio_pkg::IDX_EXT_PEND_10_17: begin
                    flag_clear[15:8] = ~wd;
                end
                irq_prio_pkg::IDX_EXT_PEND_MISC: begin
                    flag_clear[20:16] = ~wd[4:0];
                end
                default: begin
                    flag_clear = '0;
                end
            endcase
        end
        next_pending = (line_pending_bit & ~flag_clear) | line_event;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            line_pending_bit <= '0;
        end else begin
            line_pending_bit <= next_pending;
        end
    end

    // ****************************************************************
    // Priority resolution and in-service tracking.
    // ****************************************************************
    logic [23:0] pend;
    logic [23:0] en_vec;
    logic [23:0] src_on;
    logic [1:0] lvl [irq_prio_pkg::NUM_SRC];
    logic best_valid;
    logic [4:0] best_src;
    logic [1:0] best_level;
    logic any_active;
    logic [1:0] cur_level;
    logic grant;
    logic [3:0] next_in_service;

    always_comb begin
        pend = periph_irq;
        pend[irq_prio_pkg::SRC_EXT_0_7] = |line_pending_bit[7:0];
        pend[irq_prio_pkg::SRC_EXT_10_17] = |line_pending_bit[15:8];
        pend[irq_prio_pkg::SRC_EXT_MISC] = |line_pending_bit[20:16];
        en_vec = {irq_enable[3][5:0], irq_enable[2][5:0], irq_enable[1][5:0], irq_enable[0][5:0]};
        src_on = pend & en_vec;
        best_valid = 1'b0;
        best_src = 5'h00;
        best_level = 2'h0;
        for (int i = irq_prio_pkg::NUM_SRC - 1; i >= 0; i--) begin
            lvl[i] = {prio_high[i / irq_prio_pkg::SRC_PER_GROUP][i % irq_prio_pkg::SRC_PER_GROUP],
                      prio_low[i / irq_prio_pkg::SRC_PER_GROUP][i % irq_prio_pkg::SRC_PER_GROUP]};
            if (src_on[i] && (!best_valid || lvl[i] >= best_level)) begin
                best_valid = 1'b1;
                best_src = 5'(i);
                best_level = lvl[i];
            end
        end
        any_active = |in_service;
        cur_level = 2'h0;
        for (int j = 0; j < irq_prio_pkg::NUM_LEVELS; j++) begin
            if (in_service[j]) begin
                cur_level = 2'(j);
            end
        end
        grant = irq_enable[0][irq_prio_pkg::GLOBAL_EN_BIT] && best_valid
                && (!any_active || best_level > cur_level);
        next_in_service = in_service;
        if (svc_done && any_active) begin
            next_in_service[cur_level] = 1'b0;
        end
        if (irq_ack && irq_out.req) begin
            next_in_service[irq_out.level] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            in_service <= 4'h0;
        end else begin
            in_service <= next_in_service;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            irq_out <= '0;
        end else begin
            irq_out.req <= grant;
            irq_out.source <= best_src;
            irq_out.level <= best_level;
        end
    end

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    level_map_a: assert property (grant && best_src == 5'h00 |=> irq_out.level == {$past(prio_high[0][0]), $past(prio_low[0][0])}) else $error("level not formed from register pair");
    group_map_a: assert property (grant && best_src == 5'h07 |=> irq_out.level == {$past(prio_high[1][1]), $past(prio_low[1][1])}) else $error("source not mapped to its group bit");
    reset_zero_a: assert property ($rose(rst_b) |-> line_pending_bit == '0 && prio_low == '0 && line_edge_select == '0) else $error("registers not zero after reset");
    line0_set_a: assert property (line_event[0] |=> line_pending_bit[0]) else $error("line 0 edge did not set flag");
    line10_set_a: assert property (line_event[8] |=> line_pending_bit[8]) else $error("line 10 edge did not set flag");
    line8_set_a: assert property (line_event[16] |=> line_pending_bit[16]) else $error("line 8 edge did not set flag");
    clear_zero_a: assert property (wr_en && word_idx == irq_prio_pkg::IDX_EXT_PEND_0_7 && !wd[0] && !line_event[0] |=> !line_pending_bit[0]) else $error("zero write did not clear flag");
    write_one_a: assert property (wr_en && word_idx == irq_prio_pkg::IDX_EXT_PEND_0_7 && wd[0] && line_pending_bit[0] |=> line_pending_bit[0]) else $error("one write changed flag");
    no_edge_a: assert property (line_edge_select[1:0] == 2'h0 && !line_pending_bit[0] && !$rose(sync_b[0]) |=> !line_pending_bit[0]) else $error("flag set with no edge selected");
    rise_only_a: assert property (line_edge_select[1:0] == 2'h1 && sync_c[0] && !sync_b[0] |-> !line_event[0]) else $error("falling edge taken in rising mode");
    sync_edge_a: assert property (line_event[0] |-> $past(external_irq_line[0], 2) != $past(external_irq_line[0], 3)) else $error("event without synchronised pin change");
    preempt_a: assert property (irq_out.req |-> !$past(any_active) || irq_out.level > $past(cur_level)) else $error("request at or below level in service");
    tie_order_a: assert property (grant && src_on[0] && best_level == lvl[0] |=> irq_out.source == 5'h00) else $error("lower source lost a tie");
    global_off_a: assert property (!irq_enable[0][irq_prio_pkg::GLOBAL_EN_BIT] |=> !irq_out.req) else $error("request with global enable off");
    unimpl_read_a: assert property (apb_out.pready && !apb_in.pwrite && word_idx == irq_prio_pkg::IDX_EXT_PEND_MISC |-> apb_out.prdata[31:5] == '0) else $error("unimplemented bits read nonzero");

    flag_set_c: cover property (line_event[0] ##1 line_pending_bit[0]);
    preempt_c: cover property (any_active && irq_out.req);
    write_c: cover property (wr_en ##1 !apb_out.pready);

endmodule

`default_nettype wire

/* core/irq_prio_pkg.sv */
// Constants, register indices and carrier types of the interrupt priority and edge detect block.
`default_nettype none

package irq_prio_pkg;

    // ****************************************************************
    // Register indices; byte address is four times the index.
    // ****************************************************************
    localparam logic [7:0] IDX_PRIO_G0_LOW = 8'h92;
    localparam logic [7:0] IDX_PRIO_G0_HIGH = 8'h93;
    localparam logic [7:0] IDX_PRIO_G1_LOW = 8'h9a;
    localparam logic [7:0] IDX_PRIO_G1_HIGH = 8'h9b;
    localparam logic [7:0] IDX_PRIO_G2_LOW = 8'h9c;
    localparam logic [7:0] IDX_PRIO_G2_HIGH = 8'h9d;
    localparam logic [7:0] IDX_PRIO_G3_LOW = 8'h9e;
    localparam logic [7:0] IDX_PRIO_G3_HIGH = 8'h9f;
    localparam logic [7:0] IDX_EXT_PEND_0_7 = 8'ha3;
    localparam logic [7:0] IDX_EXT_PEND_10_17 = 8'ha4;
    localparam logic [7:0] IDX_EXT_PEND_MISC = 8'ha5;
    localparam logic [7:0] IDX_EDGE_SEL_0_3 = 8'ha6;
    localparam logic [7:0] IDX_EDGE_SEL_4_7 = 8'ha7;
    localparam logic [7:0] IDX_IRQ_EN_GROUP0 = 8'ha8;
    localparam logic [7:0] IDX_IRQ_EN_GROUP1 = 8'ha9;
    localparam logic [7:0] IDX_IRQ_EN_GROUP2 = 8'haa;
    localparam logic [7:0] IDX_IRQ_EN_GROUP3 = 8'hab;
    localparam logic [7:0] IDX_EDGE_SEL_10_13 = 8'hac;
    localparam logic [7:0] IDX_EDGE_SEL_14_17 = 8'had;
    localparam logic [7:0] IDX_EDGE_SEL_8_9_A = 8'hae;
    localparam logic [7:0] IDX_EDGE_SEL_18_19 = 8'haf;

    // ****************************************************************
    // Reset values and implemented-bit masks.
    // ****************************************************************
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] MASK_PRIO = 8'h3f;
    localparam logic [7:0] MASK_EN_GROUP0 = 8'hbf;
    localparam logic [7:0] MASK_EN_GROUP = 8'h3f;
    localparam logic [7:0] MASK_PEND_MISC = 8'h1f;
    localparam logic [7:0] MASK_SEL_8_9_A = 8'h3f;
    localparam logic [7:0] MASK_SEL_18_19 = 8'h0f;

    // ****************************************************************
    // Field positions and sizes.
    // ****************************************************************
    localparam int GLOBAL_EN_BIT = 7;
    localparam int SRC_PER_GROUP = 6;
    localparam int NUM_SRC = 24;
    localparam int NUM_LINES = 21;
    localparam int NUM_LEVELS = 4;
    localparam int SRC_EXT_0_7 = 5;
    localparam int SRC_EXT_10_17 = 11;
    localparam int SRC_EXT_MISC = 16;

    typedef enum logic [1:0] {
        EDGE_NONE = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_FALL = 2'h2,
        EDGE_BOTH = 2'h3
    } edge_mode_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_type;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_resp_type;

    typedef struct packed {
        logic req;
        logic [4:0] source;
        logic [1:0] level;
    } irq_vec_type;

endpackage

`default_nettype wire

/* test/pin_cpu_model.sv */
// Pin driver and CPU vector acceptance model facing the interrupt block.
`default_nettype none
module pin_cpu_model (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [20:0] pins,
    input wire logic ack_en,
    input wire irq_prio_pkg::irq_vec_type irq_out,
    output logic [20:0] external_irq_line = 21'h0,
    output logic irq_ack = 1'b0,
    output logic svc_done = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    int busy = 0;
    always @(posedge ref_clk) begin
        external_irq_line <= pins;
        irq_ack <= 1'b0;
        svc_done <= 1'b0;
        if (!rst_b || busy == 1) begin
            busy <= 0;
            svc_done <= rst_b;
        end else if (busy > 1) begin
            busy <= busy - 1;
        end else if (ack_en && irq_out.req === 1'b1) begin
            irq_ack <= 1'b1;
            busy <= 20;
        end
    end
endmodule
`default_nettype wire

/* test/irq_priority_ext_edge_detect_tb_top.sv */
// Self-checking bench of the interrupt priority and edge detect block.
`default_nettype none
module irq_priority_ext_edge_detect_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    irq_prio_pkg::apb_req_type apb_in = '0;
    irq_prio_pkg::apb_resp_type apb_out;
    irq_prio_pkg::irq_vec_type irq_out;
    logic [23:0] periph_irq = 24'h0;
    logic [20:0] pins = 21'h0;
    logic [20:0] external_irq_line;
    logic irq_ack;
    logic svc_done;
    logic ack_en = 1'b0;
    int num_errors = 0;
    int n_compared = 0;
    logic [31:0] rd;
    logic er;
    logic [31:0] seed = 32'h79a8c3fb;
    logic [7:0] regs [17] = '{8'h92, 8'h93, 8'h9a, 8'h9b, 8'h9c, 8'h9d, 8'h9e, 8'h9f, 8'ha3, 8'ha4, 8'ha5,
        8'ha6, 8'ha7, 8'hac, 8'had, 8'hae, 8'haf};
    logic [7:0] lsel [3] = '{8'ha6, 8'hac, 8'hae};
    logic [7:0] lflg [3] = '{8'ha3, 8'ha4, 8'ha5};
    int lpin [3] = '{0, 8, 16};
    irq_priority_ext_edge_detect dut (.ref_clk(ref_clk), .rst_b(rst_b), .apb_in(apb_in), .apb_out(apb_out),
        .periph_irq(periph_irq), .external_irq_line(external_irq_line), .irq_ack(irq_ack),
        .svc_done(svc_done), .irq_out(irq_out));
    pin_cpu_model partner (.ref_clk(ref_clk), .rst_b(rst_b), .pins(pins), .ack_en(ack_en), .irq_out(irq_out),
        .external_irq_line(external_irq_line), .irq_ack(irq_ack), .svc_done(svc_done));
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] mask(input logic [7:0] i);
        case (i)
            8'ha3, 8'ha4, 8'ha5: return 8'h00;
            8'ha6, 8'ha7, 8'hac, 8'had: return 8'hff;
            8'haf: return 8'h0f;
            default: return 8'h3f;
        endcase
    endfunction
    task automatic wrap_up();
        if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
        int k;
        @(posedge ref_clk);
        apb_in <= '{1'b1, 1'b0, w, {2'h0, i, 2'h0}, {24'h0, d}};
        @(posedge ref_clk);
        apb_in.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (apb_out.pready !== 1'b1 && k < 20);
        rd = apb_out.prdata;
        er = apb_out.pslverr;
        apb_in.psel <= 1'b0;
        apb_in.penable <= 1'b0;
        if (k == 20) begin
            num_errors++;
            $display("BAD %0t bus timeout", $time);
            wrap_up();
        end
    endtask
    task automatic rdc(input logic [7:0] i, input logic [31:0] exp);
        apb(1'b0, i, 8'h00);
        chk(rd, exp);
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        foreach (regs[j]) rdc(regs[j], 32'h0);
        apb(1'b1, 8'h90, 8'h55);
        chk({31'h0, er}, 32'h1);
        foreach (regs[j]) begin
            seed = lfsr(seed);
            apb(1'b1, regs[j], seed[7:0]);
            rdc(regs[j], {24'h0, seed[7:0] & mask(regs[j])});
        end
        for (int l = 0; l < 3; l++) begin
            for (int m = 0; m < 4; m++) begin
                apb(1'b1, lsel[l], 8'(m));
                pins[lpin[l]] <= 1'b1;
                repeat (8) @(posedge ref_clk);
                apb(1'b1, lflg[l], 8'hff);
                rdc(lflg[l], {31'h0, m[0]});
                apb(1'b1, lflg[l], 8'h00);
                rdc(lflg[l], 32'h0);
                pins[lpin[l]] <= 1'b0;
                repeat (8) @(posedge ref_clk);
                rdc(lflg[l], {31'h0, m[1]});
                apb(1'b1, lflg[l], 8'h00);
            end
        end
        apb(1'b1, 8'h93, 8'h00);
        apb(1'b1, 8'h92, 8'h02);
        periph_irq <= 24'h3;
        apb(1'b1, 8'ha8, 8'h83);
        repeat (3) @(posedge ref_clk);
        chk({24'h0, irq_out}, {24'h0, 1'b1, 5'd1, 2'd1});
        apb(1'b1, 8'h92, 8'h03);
        repeat (3) @(posedge ref_clk);
        chk({24'h0, irq_out}, {24'h0, 1'b1, 5'd0, 2'd1});
        ack_en <= 1'b1;
        repeat (6) @(posedge ref_clk);
        ack_en <= 1'b0;
        chk({31'h0, irq_out.req}, 32'h0);
        repeat (30) @(posedge ref_clk);
        chk({31'h0, irq_out.req}, 32'h1);
        apb(1'b1, 8'h9a, 8'h02);
        apb(1'b1, 8'h9b, 8'h02);
        periph_irq <= 24'h83;
        apb(1'b1, 8'ha9, 8'h02);
        repeat (3) @(posedge ref_clk);
        chk({24'h0, irq_out}, {24'h0, 1'b1, 5'd7, 2'd3});
        apb(1'b1, 8'ha8, 8'h03);
        repeat (3) @(posedge ref_clk);
        chk({31'h0, irq_out.req}, 32'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
